/* File: verilog/ldm_mode_ctrl.sv */
// display mode control register bank with axi4-lite slave
// Behaviour
// R1: mono depth codes 1,2,4 bpp; 11 reserved
// R2: color depth codes 1,2,4,8 bpp
// R3: memory clock pixel/8,/4,/2,/1 by depth
// R4: high performance: memory clock equals pixel
// R5: rotated mode ignores high performance
// R6: host may toggle high performance around updates
// R7: halve bit gives half input clock
// R8: landscape pixel clock equals operating clock
// R9: blank drives panel data low
// R10: frame repeat counts to 3ffff, restarts pattern
// R11: without repeat pattern never restarts
// R12: passive hw invert follows panel bit eleven
// R13: hw invert off makes bit eleven gpio
// R14: sw invert selects inverse when hw off
// R15: inversion applied after lookup table
// R16: color bit picks gray or color depth
// R17: hw invert only in passive panel mode
// R18: reserved code leaves register state intact
// R19: ratio changes are glitch free; lowering the ratio mid-count cuts that period short
module ldm_mode_ctrl #(
  parameter logic [17:0] FRAME_MAX = ldm_pkg::FRAME_LAST
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [15:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [15:0] lut_pixel,
  input  wire logic        lut_valid,
  input  wire logic        frame_start,
  input  wire logic        panel_data_bit_eleven,
  input  wire logic        general_io_four_out,
  input  wire logic        general_io_four_oe_n,
  output logic             general_io_four,
  output logic             panel_bit_eleven_out,
  output logic             panel_bit_eleven_oe_n,
  output logic [15:0]      panel_data_lines,
  output logic             op_clk_en,
  output logic             pix_clk_en,
  output logic             mem_clk_en,
  output logic [1:0]       bpp_mode,
  output logic             color_mode,
  output logic             depth_reserved,
  output logic             pattern_restart
);
  ldm_pkg::ldm_bus_t  bus_r, bus_nxt;
  ldm_pkg::ldm_core_t core_r, core_nxt;
  logic       op_en, mem_en;
  logic [3:0] ratio;
  logic       invert;
  logic       hw_inv_active;

  // memory to pixel ratio as a divisor
  function automatic logic [3:0] mem_divisor(input logic [7:0] m,
                                             input logic [7:0] p);
    logic [1:0] bpp;
    bpp = m[ldm_pkg::BPP_HI:ldm_pkg::BPP_LO];
    mem_divisor = 4'h1;
    if (p[ldm_pkg::PANEL_ROT_BIT]) begin
      mem_divisor = 4'h1;                                     // [R5]
    end else if (m[ldm_pkg::HIPERF_BIT]) begin
      mem_divisor = 4'h1;                                     // [R4]
    end else begin
      unique case (ldm_pkg::ldm_bpp_t'(bpp))
        ldm_pkg::ldm_bpp1: mem_divisor = 4'h8;                // [R3]
        ldm_pkg::ldm_bpp2: mem_divisor = 4'h4;
        ldm_pkg::ldm_bpp4: mem_divisor = 4'h2;
        ldm_pkg::ldm_bpp8: mem_divisor = 4'h1;
      endcase
    end
  endfunction

  // register decode used by both write and read paths
  function automatic logic [1:0] reg_sel(input logic [15:0] a);
    if (a == ldm_pkg::MODE_OFFSET) begin
      reg_sel = 2'h1;
    end else if (a == ldm_pkg::PANEL_OFFSET) begin
      reg_sel = 2'h2;
    end else if (a == ldm_pkg::STATUS_OFFSET) begin
      reg_sel = 2'h3;
    end else begin
      reg_sel = 2'h0;
    end
  endfunction

  assign ratio = mem_divisor(core_r.mode, core_r.panel);

  ldm_clock_div u_div (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .halve     (core_r.mode[ldm_pkg::HALVE_BIT]),
    .mem_ratio (ratio),
    .op_en     (op_en),
    .mem_en    (mem_en)
  );

  // hardware invert only exists on passive panels
  assign hw_inv_active = core_r.mode[ldm_pkg::HWINV_BIT] &
                         ~core_r.panel[ldm_pkg::PANEL_ACTIVE_BIT]; // [R17]
  assign invert = hw_inv_active ? panel_data_bit_eleven            // [R12]
                : core_r.mode[ldm_pkg::SWINV_BIT];                 // [R14]

  always_comb begin
    bus_nxt = bus_r;
    core_nxt = core_r;
    core_nxt.op_en = op_en;
    core_nxt.mem_en = mem_en;
    core_nxt.pattern_restart = 1'b0;
    // write address and data may come in either order
    if (s_axi_awvalid && !bus_r.aw_hold) begin
      bus_nxt.aw_hold = 1'b1;
      bus_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !bus_r.w_hold) begin
      bus_nxt.w_hold = 1'b1;
      bus_nxt.wdata = s_axi_wdata;
      bus_nxt.wstrb = s_axi_wstrb;
    end
    if (bus_r.aw_hold && bus_r.w_hold && !bus_r.bvalid) begin
      bus_nxt.aw_hold = 1'b0;
      bus_nxt.w_hold = 1'b0;
      bus_nxt.bvalid = 1'b1;
      bus_nxt.bresp = ldm_pkg::AXI_OKAY;
      unique case (reg_sel(bus_r.awaddr))
        2'h1: begin
          // whole byte stored even for reserved depth code
          if (bus_r.wstrb[0]) begin
            core_nxt.mode = bus_r.wdata[7:0];                 // [R18]
          end
        end
        2'h2: begin
          if (bus_r.wstrb[0]) begin
            core_nxt.panel = bus_r.wdata[7:0];
          end
        end
        2'h3: bus_nxt.bresp = ldm_pkg::AXI_OKAY;
        2'h0: bus_nxt.bresp = ldm_pkg::AXI_SLVERR;
      endcase
    end
    if (bus_r.bvalid && s_axi_bready) begin
      bus_nxt.bvalid = 1'b0;
    end
    if (s_axi_arvalid && !bus_r.rvalid) begin
      bus_nxt.rvalid = 1'b1;
      bus_nxt.rresp = ldm_pkg::AXI_OKAY;
      bus_nxt.rdata = 32'h0;
      unique case (reg_sel(s_axi_araddr))
        2'h1: bus_nxt.rdata = {24'h0, core_r.mode};
        2'h2: bus_nxt.rdata = {24'h0, core_r.panel};
        2'h3: bus_nxt.rdata = {10'h0, core_r.frame_cnt,
                               1'b0, invert, ratio[3:2]};
        2'h0: bus_nxt.rresp = ldm_pkg::AXI_SLVERR;
      endcase
    end else if (bus_r.rvalid && s_axi_rready) begin
      bus_nxt.rvalid = 1'b0;
    end
    // frame counter; without repeat the pattern simply keeps running
    if (frame_start) begin
      if (core_r.mode[ldm_pkg::REPEAT_BIT]) begin
        // limit is a parameter so a short wrap can be exercised
        if (core_r.frame_cnt == FRAME_MAX) begin
          core_nxt.frame_cnt = 18'h0;                         // [R10]
          core_nxt.pattern_restart = 1'b1;
        end else begin
          core_nxt.frame_cnt = core_r.frame_cnt + 18'h1;
        end
      end else begin
        core_nxt.frame_cnt = core_r.frame_cnt + 18'h1;        // [R11]
      end
    end
    // inversion acts on the translated pixel, blank overrides all
    if (lut_valid) begin
      core_nxt.pix_out = invert ? ~lut_pixel : lut_pixel;     // [R15]
    end
    if (core_r.mode[ldm_pkg::BLANK_BIT]) begin
      core_nxt.pix_out = 16'h0;                               // [R9]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_r <= '0;
      core_r <= '0;
    end else begin
      bus_r <= bus_nxt;
      core_r <= core_nxt;
    end
  end

  assign s_axi_awready = ~bus_r.aw_hold;
  assign s_axi_wready  = ~bus_r.w_hold;
  assign s_axi_bvalid  = bus_r.bvalid;
  assign s_axi_bresp   = bus_r.bresp;
  assign s_axi_arready = ~bus_r.rvalid;
  assign s_axi_rvalid  = bus_r.rvalid;
  assign s_axi_rdata   = bus_r.rdata;
  assign s_axi_rresp   = bus_r.rresp;

  assign panel_data_lines = core_r.pix_out;
  assign op_clk_en  = core_r.op_en;
  assign pix_clk_en = core_r.op_en;                           // [R8]
  assign mem_clk_en = core_r.mem_en;
  assign bpp_mode   = core_r.mode[ldm_pkg::BPP_HI:ldm_pkg::BPP_LO];
  assign color_mode = core_r.panel[ldm_pkg::PANEL_COLOR_BIT]; // [R16]
  assign depth_reserved = ~color_mode & (bpp_mode == 2'h3);   // [R1] [R2]
  assign pattern_restart = core_r.pattern_restart;
  // pin is gpio unless hardware invert owns it as an input
  assign general_io_four = panel_data_bit_eleven;             // [R13]
  assign panel_bit_eleven_out = general_io_four_out;
  assign panel_bit_eleven_oe_n = hw_inv_active | general_io_four_oe_n;

  blank_low_a: assert property (@(posedge aclk) // [R9]
    disable iff (!aresetn)
    core_r.mode[ldm_pkg::BLANK_BIT] |=> panel_data_lines == 16'h0)
    else $error("blank not low");
  hw_invert_a: assert property (@(posedge aclk) // [R12]
    disable iff (!aresetn)
    lut_valid && hw_inv_active && panel_data_bit_eleven
    && !core_r.mode[ldm_pkg::BLANK_BIT]
    |=> panel_data_lines == ~$past(lut_pixel))
    else $error("hw invert");
  sw_invert_a: assert property (@(posedge aclk) // [R14]
    disable iff (!aresetn)
    lut_valid && !hw_inv_active && !core_r.mode[ldm_pkg::BLANK_BIT]
    |=> panel_data_lines == ($past(core_r.mode[ldm_pkg::SWINV_BIT])
        ? ~$past(lut_pixel) : $past(lut_pixel)))
    else $error("sw invert");
  hiperf_ratio_a: assert property (@(posedge aclk) // [R4]
    disable iff (!aresetn)
    core_r.mode[ldm_pkg::HIPERF_BIT] |-> ratio == 4'h1)
    else $error("hiperf ratio");
  depth_ratio_a: assert property (@(posedge aclk) // [R3]
    disable iff (!aresetn)
    !core_r.mode[ldm_pkg::HIPERF_BIT]
    && !core_r.panel[ldm_pkg::PANEL_ROT_BIT]
    && bpp_mode == 2'h0 |-> ratio == 4'h8)
    else $error("depth ratio");
  depth2_ratio_a: assert property (@(posedge aclk) // [R3]
    disable iff (!aresetn)
    !core_r.mode[ldm_pkg::HIPERF_BIT]
    && !core_r.panel[ldm_pkg::PANEL_ROT_BIT]
    && bpp_mode == 2'h1 |-> ratio == 4'h4)
    else $error("depth ratio two");
  depth4_ratio_a: assert property (@(posedge aclk) // [R3]
    disable iff (!aresetn)
    !core_r.mode[ldm_pkg::HIPERF_BIT]
    && !core_r.panel[ldm_pkg::PANEL_ROT_BIT]
    && bpp_mode == 2'h2 |-> ratio == 4'h2)
    else $error("depth ratio four");
  depth8_ratio_a: assert property (@(posedge aclk) // [R3]
    disable iff (!aresetn)
    !core_r.mode[ldm_pkg::HIPERF_BIT]
    && !core_r.panel[ldm_pkg::PANEL_ROT_BIT]
    && bpp_mode == 2'h3 |-> ratio == 4'h1)
    else $error("depth ratio eight");
  rotate_ratio_a: assert property (@(posedge aclk) // [R5]
    disable iff (!aresetn)
    core_r.panel[ldm_pkg::PANEL_ROT_BIT] |-> ratio == 4'h1)
    else $error("rotate ratio");
  // a fresh memory period may never be cut to one cycle by a ratio write
  mem_period_a: assert property (@(posedge aclk) // [R19]
    disable iff (!aresetn)
    mem_en && ratio != 4'h1 |=> !mem_en)
    else $error("memory period short");
  op_full_a: assert property (@(posedge aclk) // [R7]
    disable iff (!aresetn)
    !core_r.mode[ldm_pkg::HALVE_BIT] |=> op_en)
    else $error("operating rate");
  repeat_wrap_a: assert property (@(posedge aclk) // [R10]
    disable iff (!aresetn)
    frame_start && core_r.mode[ldm_pkg::REPEAT_BIT]
    && core_r.frame_cnt == FRAME_MAX
    |=> pattern_restart && core_r.frame_cnt == 18'h0)
    else $error("repeat wrap");
  restart_pulse_a: assert property (@(posedge aclk) // [R10]
    disable iff (!aresetn)
    pattern_restart |=> !pattern_restart)
    else $error("restart twice");
  no_restart_a: assert property (@(posedge aclk) // [R11]
    disable iff (!aresetn)
    !$past(core_r.mode[ldm_pkg::REPEAT_BIT]) |-> !pattern_restart)
    else $error("restart without repeat");
  frame_step_a: assert property (@(posedge aclk) // [R11]
    disable iff (!aresetn)
    frame_start && !core_r.mode[ldm_pkg::REPEAT_BIT]
    |=> core_r.frame_cnt == 18'($past(core_r.frame_cnt) + 18'h1))
    else $error("frame step");
  gpio_drive_a: assert property (@(posedge aclk) // [R13]
    disable iff (!aresetn)
    !hw_inv_active |-> panel_bit_eleven_oe_n == general_io_four_oe_n
    && panel_bit_eleven_out == general_io_four_out)
    else $error("gpio drive");
  pix_is_op_a: assert property (@(posedge aclk) // [R8]
    disable iff (!aresetn)
    pix_clk_en == op_clk_en) else $error("pixel rate");
  slverr_data_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    s_axi_rvalid && s_axi_rresp == ldm_pkg::AXI_SLVERR
    |-> s_axi_rdata == 32'h0) else $error("error read data");
endmodule

/* File: verilog/ldm_pkg.sv */
// package for the lcd display mode control block
package ldm_pkg;
  localparam logic [15:0] MODE_OFFSET   = 16'hffe2;
  localparam logic [15:0] PANEL_OFFSET  = 16'hffe4;
  localparam logic [15:0] STATUS_OFFSET = 16'hffe8;
  localparam logic [7:0]  MODE_RESET    = 8'h00;
  localparam logic [7:0]  PANEL_RESET   = 8'h00;
  localparam int BPP_HI      = 7;
  localparam int BPP_LO      = 6;
  localparam int HIPERF_BIT  = 5;
  localparam int HALVE_BIT   = 4;
  localparam int BLANK_BIT   = 3;
  localparam int REPEAT_BIT  = 2;
  localparam int HWINV_BIT   = 1;
  localparam int SWINV_BIT   = 0;
  localparam int PANEL_ACTIVE_BIT = 7;
  localparam int PANEL_COLOR_BIT  = 5;
  localparam int PANEL_ROT_BIT    = 0;
  localparam logic [17:0] FRAME_LAST = 18'h3ffff;
  localparam logic [1:0]  AXI_OKAY   = 2'h0;
  localparam logic [1:0]  AXI_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ldm_bpp1, ldm_bpp2, ldm_bpp4, ldm_bpp8
  } ldm_bpp_t;

  typedef struct packed {
    logic       aw_hold;
    logic       w_hold;
    logic [15:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } ldm_bus_t;

  typedef struct packed {
    logic [7:0]  mode;
    logic [7:0]  panel;
    logic        half_ph;
    logic [2:0]  mdiv;
    logic [17:0] frame_cnt;
    logic        pattern_restart;
    logic        op_en;
    logic        mem_en;
    logic [15:0] pix_out;
  } ldm_core_t;
endpackage

/* File: verilog/ldm_clock_div.sv */
// clock enable divider for operating, pixel and memory rates
module ldm_clock_div (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       halve,
  input  wire logic [3:0] mem_ratio,
  output logic            op_en,
  output logic            mem_en
);
  typedef struct packed {
    logic       ph;
    logic [2:0] cnt;
    logic       op;
    logic       mem;
  } ldm_div_t;
  ldm_div_t st_r, st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.ph = halve ? ~st_r.ph : 1'b0;
    st_nxt.op = ~halve | st_r.ph;                             // [R7]
    st_nxt.mem = 1'b0;
    if (st_nxt.op) begin
      // ratio compared on every operating cycle, so lowering it wraps the count early and can cut a period short
      if (st_r.cnt >= 3'(mem_ratio - 4'h1)) begin               // [R19]
        st_nxt.cnt = 3'h0;
        st_nxt.mem = 1'b1;                                    // [R3]
      end else begin
        st_nxt.cnt = st_r.cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign op_en  = st_r.op;
  assign mem_en = st_r.mem;

  op_rate_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
    halve && $past(halve) && op_en |=> !op_en) else $error("op rate");
endmodule

/* File: testbench/ldm_panel_model.sv */
// panel side model: drives the invert input on bit eleven
module ldm_panel_model (
  input  wire logic drive_en,
  input  wire logic drive_val,
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  output logic      pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // device drive wins; a released line sits on its pull-up, not last value
  assign pin = !pin_oe_n ? pin_out : (drive_en ? drive_val : 1'b1);
endmodule

/* File: testbench/tb_lcd_display_mode_control.sv */
// testbench for the display mode control block
module tb_lcd_display_mode_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic [15:0] s_axi_awaddr, s_axi_araddr, lut_pixel, panel_data_lines;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, bpp_mode, rs;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, lut_valid;
  logic        frame_start, panel_data_bit_eleven, general_io_four_out;
  logic        general_io_four_oe_n, general_io_four, panel_bit_eleven_out;
  logic        panel_bit_eleven_oe_n, op_clk_en, pix_clk_en, mem_clk_en;
  logic        color_mode, depth_reserved, pattern_restart, drv_en, drv_val;
  logic [7:0]  m;
  int          mismatches, samples_checked, op_n, mem_n, pix_n, i, restarts;
  logic [7:0]  pm [5] = '{8'h00, 8'h01, 8'h08, 8'h02, 8'h03};
  logic        pv [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  logic [15:0] pe [5] = '{16'ha5c3, 16'h5a3c, 16'h0000, 16'h5a3c, 16'ha5c3};

  // short frame limit so the repeat wrap is reached within the run
  ldm_mode_ctrl #(.FRAME_MAX(18'h7)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .lut_pixel, .lut_valid, .frame_start, .panel_data_bit_eleven,
    .general_io_four_out, .general_io_four_oe_n, .general_io_four,
    .panel_bit_eleven_out, .panel_bit_eleven_oe_n, .panel_data_lines,
    .op_clk_en, .pix_clk_en, .mem_clk_en, .bpp_mode, .color_mode,
    .depth_reserved, .pattern_restart
  );

  ldm_panel_model panel (
    .drive_en(drv_en), .drive_val(drv_val), .pin_out(panel_bit_eleven_out),
    .pin_oe_n(panel_bit_eleven_oe_n), .pin(panel_data_bit_eleven)
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    restarts <= restarts + int'(pattern_restart);
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string s);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %0s seen %h want %h", $time, s, seen, exp);
    end
  endtask

  task wr(input logic [15:0] a, input logic [7:0] d);
    bit got;
    got = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    repeat (100) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      got = s_axi_bvalid;
      if (got) break;
    end
    if (!got) chk(32'h0, 32'h1, "write timeout");
    s_axi_bready <= 1'b0;
    rs = s_axi_bresp;
  endtask

  task rdr(input logic [15:0] a);
    bit got;
    got = 1'b0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    repeat (100) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      got = s_axi_rvalid;
      if (got) break;
    end
    if (!got) chk(32'h0, 32'h1, "read timeout");
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask

  task frames(input int n);
    repeat (n) begin
      @(posedge aclk);
      frame_start <= 1'b1;
      @(posedge aclk);
      frame_start <= 1'b0;
    end
  endtask

  task setm(input logic [7:0] d);
    wr(ldm_pkg::MODE_OFFSET, d);
    repeat (3) @(posedge aclk);
  endtask

  // ratio changes apply on the next operating cycle, so let it settle before counting
  task meas();
    op_n = 0;
    mem_n = 0;
    pix_n = 0;
    repeat (32) @(posedge aclk);
    repeat (64) begin
      @(posedge aclk);
      op_n += int'(op_clk_en);
      mem_n += int'(mem_clk_en);
      pix_n += int'(pix_clk_en);
    end
  endtask

  task summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    summarize();
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, lut_valid, frame_start} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, lut_pixel} = 48'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h1;
    {general_io_four_out, drv_val} = 2'h0;
    {general_io_four_oe_n, drv_en} = 2'h3;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(ldm_pkg::MODE_OFFSET);
    chk(rd, {24'h0, ldm_pkg::MODE_RESET}, "mode reset");
    rdr(16'hfff0);
    chk({rd[29:0], rs}, {30'h0, ldm_pkg::AXI_SLVERR}, "unmapped read");
    wr(16'hfff0, 8'hff);
    chk({30'h0, rs}, {30'h0, ldm_pkg::AXI_SLVERR}, "unmapped write");
    wr(ldm_pkg::PANEL_OFFSET, 8'h20);
    chk({30'h0, rs}, {30'h0, ldm_pkg::AXI_OKAY}, "write response");
    $display("test registers done");
    for (i = 0; i < 8; i++) begin
      m = {i[1:0], i[2], 5'h00};
      setm(m);
      rdr(ldm_pkg::MODE_OFFSET);
      chk(rd, {24'h0, m}, "mode readback");
      chk({30'h0, bpp_mode}, {30'h0, i[1:0]}, "color depth");
      meas();
      chk(32'(mem_n), i[2] ? 32'd64 : 32'd8 << i[1:0], "mem rate");
      chk(32'(pix_n), 32'(op_n), "pixel rate");
    end
    setm(8'h10);
    meas();
    chk(32'(op_n), 32'd32, "halved rate");
    chk(32'(mem_n), 32'd4, "halved mem rate");
    $display("test clocks done");
    wr(ldm_pkg::PANEL_OFFSET, 8'h00);
    setm(8'hc0);
    chk({31'h0, depth_reserved}, 32'h1, "reserved depth");
    chk({31'h0, color_mode}, 32'h0, "mono select");
    rdr(ldm_pkg::MODE_OFFSET);
    chk(rd, 32'hc0, "reserved readback");
    setm(8'h80);
    chk({29'h0, depth_reserved, bpp_mode}, 32'h2, "mono depth");
    $display("test depth done");
    lut_pixel <= 16'ha5c3;
    lut_valid <= 1'b1;
    for (i = 0; i < 5; i++) begin
      drv_val <= pv[i];
      setm(pm[i]);
      chk({16'h0, panel_data_lines}, {16'h0, pe[i]}, "pixel");
    end
    drv_en <= 1'b0;
    general_io_four_out <= 1'b1;
    general_io_four_oe_n <= 1'b0;
    setm(8'h00);
    chk({29'h0, panel_bit_eleven_oe_n, panel_bit_eleven_out, general_io_four},
        32'h3, "gpio mode");
    general_io_four_oe_n <= 1'b1;
    setm(8'h02);
    chk({31'h0, panel_bit_eleven_oe_n}, 32'h1, "invert input");
    $display("test video done");
    setm(8'h04);
    frames(3);
    rdr(ldm_pkg::STATUS_OFFSET);
    chk({14'h0, rd[21:4]}, 32'h3, "frame count");
    frames(5);
    rdr(ldm_pkg::STATUS_OFFSET);
    chk({14'h0, rd[21:4]}, 32'h0, "frame wrap");
    chk(32'(restarts), 32'h1, "pattern restart");
    setm(8'h00);
    frames(9);
    rdr(ldm_pkg::STATUS_OFFSET);
    chk({14'h0, rd[21:4]}, 32'h9, "frame run on");
    chk(32'(restarts), 32'h1, "no restart");
    chk({28'h0, rd[3:0]}, 32'h2, "status ratio");
    $display("test frames done");
    summarize();
  end
endmodule
